// *** logic/tbs_pkg.sv ***
// package for the touch button and slider decision block
// assumes a 125 MHz system clock and one scan strobe per scan period from the front end
`default_nettype none
package tbs_pkg;
    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_BUTTON_REPORT_CONFIG = 8'h21;
    localparam logic [7:0] ADDR_BUTTON_AVG_HOLD = 8'h22;
    localparam logic [7:0] ADDR_BUTTON_NEG_COMP = 8'h23;
    localparam logic [7:0] ADDR_BUTTON_NEG_LIMIT = 8'h24;
    localparam logic [7:0] ADDR_BUTTON_HYST = 8'h25;
    localparam logic [7:0] ADDR_BUTTON_STUCK = 8'h26;
    localparam logic [7:0] ADDR_SLIDER_DEBOUNCE = 8'h27;
    localparam logic [7:0] ADDR_SLIDER_STUCK = 8'h28;
    localparam logic [7:0] ADDR_SLIDER_HYST = 8'h29;
    localparam logic [7:0] ADDR_SLIDER_NORM_HIGH = 8'h2B;
    localparam logic [7:0] ADDR_SLIDER_NORM_LOW = 8'h2C;
    localparam logic [7:0] ADDR_SLIDER_MOVE = 8'h30;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] RST_BUTTON_REPORT_CONFIG = 8'h30;
    localparam logic [7:0] RST_BUTTON_AVG_HOLD = 8'h50;
    localparam logic [7:0] RST_BUTTON_NEG_COMP = 8'h50;
    localparam logic [7:0] RST_BUTTON_NEG_LIMIT = 8'h01;
    localparam logic [7:0] RST_BUTTON_HYST = 8'h0A;
    localparam logic [7:0] RST_STUCK = 8'h00;
    localparam logic [3:0] RST_SLIDER_DEBOUNCE = 4'h0;
    localparam logic [7:0] RST_SLIDER_HYST = 8'h03;
    localparam logic [15:0] RST_SLIDER_NORM = 16'h0180;
    localparam logic [7:0] RST_SLIDER_MOVE = 8'h02;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int TOUCH_DEB_LSB = 0;
    localparam int RELEASE_DEB_LSB = 2;
    localparam int IRQ_SEL_LSB = 4;
    localparam int REPORT_MODE_LSB = 6;
    localparam logic [1:0] REPORT_SINGLE = 2'h1;
    localparam int IRQ_ON_TOUCH_BIT = 0;
    localparam int IRQ_ON_RELEASE_BIT = 1;
    localparam logic [7:0] TIMEOUT_OFF = 8'h00;
    localparam int TICK_STEP = 4;
    localparam int PCT_FULL = 100;
    localparam int NORM_SHIFT = 5;
    localparam int AVG_HOLD_COMP_COUNT = 3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_KHZ = 125000;
    localparam int SECOND_MS = 1000;
    localparam int SEC_CYCLES = SECOND_MS * CLK_KHZ;

    // samples needed for a decision: 00 -> 1 (incoming sample), 01 -> 2, 10 -> 3, 11 -> 4
    function automatic logic [2:0] tbs_deb_need(input logic [1:0] code);
        return {1'b0, code} + 3'h1;
    endfunction
endpackage
`default_nettype wire

// *** logic/tbs_decide.sv ***
// touch/release decision of one button or the slider: debounce and stuck-at timeout
// assumes i_over/i_under/i_sec are valid in the cycle of the i_scan strobe
`timescale 1ns/1ns
`default_nettype none
module tbs_decide (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scan,
    input wire logic i_sec,
    input wire logic i_over,
    input wire logic i_under,
    input wire logic [1:0] i_touch_code,
    input wire logic [1:0] i_release_code,
    input wire logic [7:0] i_timeout,
    output logic o_touched,
    output logic o_touch_evt,
    output logic o_release_evt
);
    import tbs_pkg::*;

    logic [2:0] cnt;
    logic [7:0] secs;
    logic stuck;

    wire [2:0] cnt_inc = cnt + 3'h1;
    wire touch_done = i_over && (cnt_inc >= tbs_deb_need(i_touch_code));
    wire release_done = i_under && (cnt_inc >= tbs_deb_need(i_release_code));
    wire [8:0] secs_inc = {1'b0, secs} + 9'h001;
    wire timeout_hit = (i_timeout != TIMEOUT_OFF) && i_sec && (secs_inc >= {1'b0, i_timeout});

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_touched <= 1'b0;
            o_touch_evt <= 1'b0;
            o_release_evt <= 1'b0;
            cnt <= 3'h0;
            secs <= 8'h00;
            stuck <= 1'b0;
        end else begin
            o_touch_evt <= 1'b0;
            o_release_evt <= 1'b0;
            if (i_scan) begin
                if (stuck) begin
                    // forced release stays until the finger really lifts
                    cnt <= 3'h0;
                    if (i_under) begin
                        stuck <= 1'b0;
                    end
                end else if (!o_touched) begin
                    secs <= 8'h00;
                    if (touch_done) begin
                        o_touched <= 1'b1;
                        o_touch_evt <= 1'b1;
                        cnt <= 3'h0;
                    end else begin
                        cnt <= i_over ? cnt_inc : 3'h0;
                    end
                end else if (release_done) begin
                    o_touched <= 1'b0;
                    o_release_evt <= 1'b1;
                    cnt <= 3'h0;
                end else if (timeout_hit) begin
                    o_touched <= 1'b0;
                    o_release_evt <= 1'b1;
                    stuck <= 1'b1;
                    cnt <= 3'h0;
                end else begin
                    cnt <= i_under ? cnt_inc : 3'h0;
                    if (i_sec) begin
                        secs <= secs_inc[7:0];
                    end
                end
            end
        end
    end
endmodule // tbs_decide
`default_nettype wire

// *** logic/tbs_top.sv ***
// button and slider decision logic fed by the capacitive front end once per scan
// assumes i_scan is a one-cycle strobe per scan period with i_ticks and i_slider_position valid with it
`timescale 1ns/1ns
`default_nettype none
module tbs_top #(
    parameter int N_SENSORS = 8,
    parameter int TICK_W = 16,
    parameter logic [7:0] SLIDER_MASK = 8'hFC,
    parameter int SLIDER_SENSORS = 6,
    parameter int SEC_CYCLES = tbs_pkg::SEC_CYCLES
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scan,
    input wire logic [N_SENSORS*TICK_W-1:0] i_ticks,
    input wire logic [N_SENSORS*TICK_W-1:0] i_sensor_touch_threshold,
    input wire logic [15:0] i_slider_position,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic [N_SENSORS-1:0] o_button_touched,
    output logic o_slider_touched,
    output logic o_slider_move_up,
    output logic o_slider_move_down,
    output logic o_irq,
    output logic [N_SENSORS-1:0] o_avg_hold,
    output logic o_comp_start
);
    import tbs_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0] button_report_config;
    logic [7:0] button_average_hold_threshold;
    logic [7:0] button_negative_comp_threshold;
    logic [7:0] button_negative_count_limit;
    logic [7:0] button_hysteresis_percent;
    logic [7:0] button_stuck_timeout;
    logic [3:0] slider_debounce_config;
    logic [7:0] slider_stuck_timeout;
    logic [7:0] slider_hysteresis;
    logic [7:0] slider_norm_high;
    logic [7:0] slider_norm_low;
    logic [7:0] slider_move_threshold;

    wire wr_report = i_reg_wr && (i_reg_addr == ADDR_BUTTON_REPORT_CONFIG);
    wire wr_avg = i_reg_wr && (i_reg_addr == ADDR_BUTTON_AVG_HOLD);
    wire wr_neg = i_reg_wr && (i_reg_addr == ADDR_BUTTON_NEG_COMP);
    wire wr_limit = i_reg_wr && (i_reg_addr == ADDR_BUTTON_NEG_LIMIT);
    wire wr_hyst = i_reg_wr && (i_reg_addr == ADDR_BUTTON_HYST);
    wire wr_stuck = i_reg_wr && (i_reg_addr == ADDR_BUTTON_STUCK);
    wire wr_sdeb = i_reg_wr && (i_reg_addr == ADDR_SLIDER_DEBOUNCE);
    wire wr_sstuck = i_reg_wr && (i_reg_addr == ADDR_SLIDER_STUCK);
    wire wr_shyst = i_reg_wr && (i_reg_addr == ADDR_SLIDER_HYST);
    wire wr_nhigh = i_reg_wr && (i_reg_addr == ADDR_SLIDER_NORM_HIGH);
    wire wr_nlow = i_reg_wr && (i_reg_addr == ADDR_SLIDER_NORM_LOW);
    wire wr_move = i_reg_wr && (i_reg_addr == ADDR_SLIDER_MOVE);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            button_report_config <= RST_BUTTON_REPORT_CONFIG;
            button_average_hold_threshold <= RST_BUTTON_AVG_HOLD;
            button_negative_comp_threshold <= RST_BUTTON_NEG_COMP;
            button_negative_count_limit <= RST_BUTTON_NEG_LIMIT;
            button_hysteresis_percent <= RST_BUTTON_HYST;
            button_stuck_timeout <= RST_STUCK;
            slider_debounce_config <= RST_SLIDER_DEBOUNCE;
            slider_stuck_timeout <= RST_STUCK;
            slider_hysteresis <= RST_SLIDER_HYST;
            slider_norm_high <= RST_SLIDER_NORM[15:8];
            slider_norm_low <= RST_SLIDER_NORM[7:0];
            slider_move_threshold <= RST_SLIDER_MOVE;
        end else begin
            if (wr_report) button_report_config <= i_reg_wdata;
            if (wr_avg) button_average_hold_threshold <= i_reg_wdata;
            if (wr_neg) button_negative_comp_threshold <= i_reg_wdata;
            if (wr_limit) button_negative_count_limit <= i_reg_wdata;
            if (wr_hyst) button_hysteresis_percent <= i_reg_wdata;
            if (wr_stuck) button_stuck_timeout <= i_reg_wdata;
            if (wr_sdeb) slider_debounce_config <= i_reg_wdata[3:0];
            if (wr_sstuck) slider_stuck_timeout <= i_reg_wdata;
            if (wr_shyst) slider_hysteresis <= i_reg_wdata;
            if (wr_nhigh) slider_norm_high <= i_reg_wdata;
            if (wr_nlow) slider_norm_low <= i_reg_wdata;
            if (wr_move) slider_move_threshold <= i_reg_wdata;
        end
    end

    logic [7:0] rd_mux;
    always_comb begin
        unique case (i_reg_addr)
            ADDR_BUTTON_REPORT_CONFIG: rd_mux = button_report_config;
            ADDR_BUTTON_AVG_HOLD: rd_mux = button_average_hold_threshold;
            ADDR_BUTTON_NEG_COMP: rd_mux = button_negative_comp_threshold;
            ADDR_BUTTON_NEG_LIMIT: rd_mux = button_negative_count_limit;
            ADDR_BUTTON_HYST: rd_mux = button_hysteresis_percent;
            ADDR_BUTTON_STUCK: rd_mux = button_stuck_timeout;
            ADDR_SLIDER_DEBOUNCE: rd_mux = {4'h0, slider_debounce_config};
            ADDR_SLIDER_STUCK: rd_mux = slider_stuck_timeout;
            ADDR_SLIDER_HYST: rd_mux = slider_hysteresis;
            ADDR_SLIDER_NORM_HIGH: rd_mux = slider_norm_high;
            ADDR_SLIDER_NORM_LOW: rd_mux = slider_norm_low;
            ADDR_SLIDER_MOVE: rd_mux = slider_move_threshold;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_rdata <= rd_mux;
        end
    end

    // ****************************************************************
    // seconds timebase, held until the next scan consumes it
    // ****************************************************************
    logic [31:0] sec_cnt;
    logic sec_pending;
    wire sec_wrap = (sec_cnt == 32'(SEC_CYCLES - 1));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sec_cnt <= 32'h0;
            sec_pending <= 1'b0;
        end else begin
            sec_cnt <= sec_wrap ? 32'h0 : sec_cnt + 32'h1;
            if (sec_wrap) begin
                sec_pending <= 1'b1;
            end else if (i_scan) begin
                sec_pending <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // per-sensor comparisons and button decisions
    // ****************************************************************
    wire signed [31:0] pct = 32'(button_hysteresis_percent);
    wire signed [31:0] on_scale = 32'(PCT_FULL) + pct;
    wire signed [31:0] off_scale = 32'(PCT_FULL) - pct;
    wire signed [31:0] avg_lvl = 32'(button_average_hold_threshold) * 32'(TICK_STEP);
    wire signed [31:0] neg_lvl = -(32'(button_negative_comp_threshold) * 32'(TICK_STEP));
    wire [8:0] limit_x = {1'b0, button_negative_count_limit};

    logic [N_SENSORS-1:0] hold_now;
    logic [N_SENSORS-1:0] neg_trip;
    logic [N_SENSORS-1:0] btn_touched;
    logic [N_SENSORS-1:0] btn_touch_evt;
    logic [31:0] press_part [N_SENSORS];
    logic comp_fire;

    genvar gi;
    generate
        for (gi = 0; gi < N_SENSORS; gi++) begin : g_sensor
            wire signed [31:0] tick_x = 32'(signed'(i_ticks[gi*TICK_W +: TICK_W]));
            wire signed [31:0] th_x = 32'(i_sensor_touch_threshold[gi*TICK_W +: TICK_W]);
            wire over = (tick_x * 32'(PCT_FULL)) > (th_x * on_scale);
            wire under = (tick_x * 32'(PCT_FULL)) < (th_x * off_scale);
            wire below = tick_x < neg_lvl;
            wire is_button = !SLIDER_MASK[gi];
            logic [7:0] neg_cnt;
            wire [8:0] neg_inc = {1'b0, neg_cnt} + 9'h001;

            assign hold_now[gi] = tick_x >= avg_lvl;
            assign neg_trip[gi] = below && (neg_inc >= limit_x);
            assign press_part[gi] = (SLIDER_MASK[gi] && tick_x > th_x) ? 32'(tick_x - th_x) : 32'h0;

            always_ff @(posedge i_clk_sys) begin
                if (i_rst) begin
                    neg_cnt <= 8'h00;
                    o_avg_hold[gi] <= 1'b0;
                end else if (i_scan) begin
                    o_avg_hold[gi] <= hold_now[gi];
                    if (comp_fire || !below) begin
                        neg_cnt <= 8'h00;
                    end else if (neg_cnt != 8'hFF) begin
                        neg_cnt <= neg_inc[7:0];
                    end
                end
            end

            tbs_decide u_button (
                .i_clk_sys(i_clk_sys),
                .i_rst(i_rst),
                .i_scan(i_scan),
                .i_sec(sec_pending),
                .i_over(over && is_button),
                .i_under(under || !is_button),
                .i_touch_code(button_report_config[TOUCH_DEB_LSB +: 2]),
                .i_release_code(button_report_config[RELEASE_DEB_LSB +: 2]),
                .i_timeout(button_stuck_timeout),
                .o_touched(btn_touched[gi]),
                .o_touch_evt(btn_touch_evt[gi]),
                .o_release_evt()
            );
        end
    endgenerate

    // ****************************************************************
    // offset compensation request
    // ****************************************************************
    logic [7:0] hold_count;
    always_comb begin
        hold_count = 8'h00;
        for (int k = 0; k < N_SENSORS; k++) begin
            hold_count = hold_count + {7'h00, hold_now[k]};
        end
    end
    assign comp_fire = i_scan && ((hold_count >= 8'(AVG_HOLD_COMP_COUNT)) || (|neg_trip));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_comp_start <= 1'b0;
        end else begin
            o_comp_start <= comp_fire;
        end
    end

    // ****************************************************************
    // reporting and interrupt
    // ****************************************************************
    wire single_mode = button_report_config[REPORT_MODE_LSB +: 2] == REPORT_SINGLE;
    wire [N_SENSORS-1:0] first_evt = btn_touch_evt & (-btn_touch_evt);
    wire [N_SENSORS-1:0] owner_held = o_button_touched & btn_touched;
    wire [N_SENSORS-1:0] next_report = single_mode ? ((|owner_held) ? owner_held : first_evt)
                                                   : btn_touched;
    wire rose = |(next_report & ~o_button_touched);
    wire fell = |(o_button_touched & ~next_report);
    wire next_irq = (button_report_config[IRQ_SEL_LSB + IRQ_ON_TOUCH_BIT] && rose)
                 || (button_report_config[IRQ_SEL_LSB + IRQ_ON_RELEASE_BIT] && fell);

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_button_touched <= '0;
            o_irq <= 1'b0;
        end else begin
            o_button_touched <= next_report;
            o_irq <= next_irq;
        end
    end

    // ****************************************************************
    // slider
    // ****************************************************************
    logic [31:0] pressure;
    always_comb begin
        pressure = 32'h0;
        for (int k = 0; k < N_SENSORS; k++) begin
            pressure = pressure + press_part[k];
        end
    end

    wire [31:0] sld_hyst = 32'(slider_hysteresis) * 32'(TICK_STEP);
    logic sld_touched;

    tbs_decide u_slider (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_scan(i_scan),
        .i_sec(sec_pending),
        .i_over(pressure > sld_hyst),
        .i_under(pressure == 32'h0),
        .i_touch_code(slider_debounce_config[TOUCH_DEB_LSB +: 2]),
        .i_release_code(slider_debounce_config[RELEASE_DEB_LSB +: 2]),
        .i_timeout(slider_stuck_timeout),
        .o_touched(sld_touched),
        .o_touch_evt(),
        .o_release_evt()
    );

    wire [15:0] slider_norm = {slider_norm_high, slider_norm_low};
    wire [31:0] pos_max = 32'(slider_norm >> NORM_SHIFT) * 32'(SLIDER_SENSORS - 1);
    logic [15:0] prev_pos;
    wire going_up = i_slider_position > prev_pos;
    wire [15:0] pos_diff = going_up ? i_slider_position - prev_pos : prev_pos - i_slider_position;
    wire moved = sld_touched && (32'(pos_diff) * 32'(PCT_FULL) > pos_max * 32'(slider_move_threshold));

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            prev_pos <= 16'h0000;
            o_slider_move_up <= 1'b0;
            o_slider_move_down <= 1'b0;
            o_slider_touched <= 1'b0;
        end else begin
            o_slider_touched <= sld_touched;
            if (i_scan) begin
                prev_pos <= i_slider_position;
                o_slider_move_up <= moved && going_up;
                o_slider_move_down <= moved && !going_up;
            end
        end
    end
endmodule // tbs_top
`default_nettype wire

// *** verification/tbs_fe_model.sv ***
// front end model: scan strobe every 4 cycles and tick values set by the bench
// assumes the bench calls set_tick and that o_comp_start comes from the dut
`timescale 1ns/1ns
`default_nettype none
module tbs_fe_model (
    input wire logic i_clk_sys,
    input wire logic i_comp_start,
    output logic o_scan,
    output logic [127:0] o_ticks,
    output logic [15:0] o_position
);
    logic [1:0] cnt = 2'h0;
    logic [127:0] ticks = '0;
    task automatic set_tick(input int k, input logic [15:0] v);
        ticks[k*16+:16] = v;
    endtask
    always @(posedge i_clk_sys) begin
        cnt <= cnt + 2'h1;
        if (i_comp_start) ticks <= '0;
    end
    assign o_scan = (cnt == 2'h0);
    // outside the strobe the lines carry junk
    assign o_ticks = o_scan ? ticks : ~ticks;
    assign o_position = o_scan ? 16'h0000 : 16'hFFFF;
endmodule // tbs_fe_model
`default_nettype wire

// *** verification/tbs_sva.sv ***
// assertions on the ports of tbs_top
// assumes the averaging hold threshold keeps its reset value
`timescale 1ns/1ns
`default_nettype none
module tbs_sva import tbs_pkg::*; #(
    parameter int N_SENSORS = 8,
    parameter int TICK_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_scan,
    input wire logic [N_SENSORS*TICK_W-1:0] i_ticks,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [N_SENSORS-1:0] o_button_touched,
    input wire logic o_slider_touched,
    input wire logic o_irq,
    input wire logic [N_SENSORS-1:0] o_avg_hold,
    input wire logic o_comp_start
);
    logic [N_SENSORS-1:0] over;
    logic [N_SENSORS-1:0] over_q;
    always_comb for (int k = 0; k < N_SENSORS; k++) over[k] = $signed(i_ticks[k*TICK_W+:TICK_W]) >= 320;
    always_ff @(posedge i_clk_sys) if (i_scan) over_q <= over;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_irq_cause; o_irq |-> o_button_touched != $past(o_button_touched); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without button change");
    property p_btn_scan; $changed(o_button_touched) |-> $past(i_scan, 2) || $past(i_scan, 3); endproperty
    a_btn_scan: assert property (p_btn_scan) else $error("button state moved off scan");
    property p_hold; i_scan |-> ##[1:2] (o_avg_hold == over_q); endproperty
    a_hold: assert property (p_hold) else $error("averaging hold wrong");
    property p_comp3; i_scan && $countones(over) >= AVG_HOLD_COMP_COUNT |-> ##[1:2] o_comp_start; endproperty
    a_comp3: assert property (p_comp3) else $error("no compensation for three held sensors");
    property p_comp_pulse; o_comp_start |-> ($past(i_scan) || $past(i_scan, 2)) ##1 !o_comp_start; endproperty
    a_comp_pulse: assert property (p_comp_pulse) else $error("compensation request malformed");
    property p_resv; $past(i_reg_addr) == ADDR_SLIDER_DEBOUNCE |-> o_reg_rdata[7:4] == 4'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved slider bits read nonzero");
    property p_gap; $past(i_reg_addr) == 8'h2A |-> o_reg_rdata == 8'h00; endproperty
    a_gap: assert property (p_gap) else $error("gap beside norm reads nonzero");
    property p_sld_scan; $changed(o_slider_touched) |-> $past(i_scan, 2) || $past(i_scan, 3); endproperty
    a_sld_scan: assert property (p_sld_scan) else $error("slider state moved off scan");
    c_irq: cover property (o_irq);
    c_comp: cover property (o_comp_start);
    c_sld: cover property ($rose(o_slider_touched));
endmodule // tbs_sva
bind tbs_top tbs_sva #(.N_SENSORS(N_SENSORS), .TICK_W(TICK_W)) i_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_scan(i_scan), .i_ticks(i_ticks), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
    .o_button_touched(o_button_touched), .o_slider_touched(o_slider_touched), .o_irq(o_irq),
    .o_avg_hold(o_avg_hold), .o_comp_start(o_comp_start));
`default_nettype wire

// *** verification/tbs_top_bench.sv ***
// self-checking bench for tbs_top with the front end model
// assumes thresholds of 100 ticks on every sensor and a short second
`timescale 1ns/1ns
`default_nettype none
module tbs_top_bench;
    import tbs_pkg::*;
    localparam logic [207:0] RV = 208'h2130_2250_2350_2401_250A_2600_2700_2800_2903_2A00_2B01_2C80_3002;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic i_reg_wr = 1'b0;
    logic [7:0] i_reg_addr = 8'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic scan, irq, comp, sld;
    logic [127:0] ticks;
    logic [15:0] pos;
    logic [7:0] rdata, btn, hold;
    int err_count = 0;
    int samples_checked = 0;
    int irq_cnt = 0;
    int comp_cnt = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        irq_cnt <= irq_cnt + (irq === 1'b1);
        comp_cnt <= comp_cnt + (comp === 1'b1);
    end
    tbs_fe_model i_fe (.i_clk_sys(i_clk_sys), .i_comp_start(comp), .o_scan(scan), .o_ticks(ticks), .o_position(pos));
    tbs_top #(.SEC_CYCLES(20)) i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_scan(scan), .i_ticks(ticks),
        .i_sensor_touch_threshold({8{16'h0064}}), .i_slider_position(pos), .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(rdata), .o_button_touched(btn),
        .o_slider_touched(sld), .o_slider_move_up(), .o_slider_move_down(), .o_irq(irq), .o_avg_hold(hold),
        .o_comp_start(comp));
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys) #1;
        {i_reg_wr, i_reg_addr, i_reg_wdata} = {1'b1, a, d};
        @(posedge i_clk_sys) #1;
        i_reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk_sys) #1;
        i_reg_addr = a;
        repeat (2) @(posedge i_clk_sys) #1;
    endtask
    // wait for n scans, then until their decisions have settled
    task automatic scans(input int n);
        repeat (n) @(posedge i_clk_sys iff scan === 1'b1);
        if (n > 0) repeat (3) @(posedge i_clk_sys) #1;
    endtask
    task automatic t_regs();
        for (int i = 0; i < 13; i++) begin
            rd(RV[i*16+8+:8]);
            check("reset value", rdata, RV[i*16+:8]);
        end
        wr(ADDR_SLIDER_DEBOUNCE, 8'hFF);
        wr(ADDR_SLIDER_NORM_HIGH, 8'h12);
        wr(ADDR_SLIDER_NORM_LOW, 8'h34);
        rd(ADDR_SLIDER_DEBOUNCE);
        check("slider debounce", rdata, 8'h0F);
        rd(ADDR_SLIDER_NORM_HIGH);
        check("norm high", rdata, 8'h12);
        rd(ADDR_SLIDER_NORM_LOW);
        check("norm low", rdata, 8'h34);
    endtask
    task automatic t_debounce();
        for (int c = 0; c < 4; c++) begin
            wr(ADDR_BUTTON_REPORT_CONFIG, 8'h30 | 8'(c) | 8'(c << 2));
            i_fe.set_tick(c % 2, 16'h006E);
            scans(1);
            check("at touch level", btn, 8'h00);
            i_fe.set_tick(c % 2, 16'h006F);
            scans(c);
            check("touch debounce", btn, 8'h00);
            scans(1);
            check("touch", btn, 8'h01 << (c % 2));
            i_fe.set_tick(c % 2, 16'h005A);
            scans(1);
            check("at release level", btn, 8'h01 << (c % 2));
            i_fe.set_tick(c % 2, 16'h0059);
            scans(c);
            check("release debounce", btn, 8'h01 << (c % 2));
            scans(1);
            check("release", btn, 8'h00);
        end
    endtask
    task automatic t_single();
        wr(ADDR_BUTTON_REPORT_CONFIG, 8'h70);
        i_fe.set_tick(0, 16'h00C8);
        scans(1);
        i_fe.set_tick(1, 16'h00C8);
        scans(1);
        check("single report", btn, 8'h01);
        i_fe.set_tick(0, 16'h0000);
        scans(1);
        check("single owner released", btn[0], 1'b0);
        i_fe.set_tick(1, 16'h0000);
        scans(2);
    endtask
    task automatic t_irq();
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_BUTTON_REPORT_CONFIG, 8'(s << 4));
            irq_cnt = 0;
            i_fe.set_tick(1, 16'h00C8);
            scans(1);
            i_fe.set_tick(1, 16'h0000);
            scans(1);
            check("irq count", irq_cnt[15:0], 16'(s % 2) + 16'(s / 2));
        end
    endtask
    task automatic t_stuck();
        wr(ADDR_BUTTON_REPORT_CONFIG, 8'h30);
        i_fe.set_tick(0, 16'h00C8);
        scans(12);
        check("no timeout", btn, 8'h01);
        i_fe.set_tick(0, 16'h0000);
        wr(ADDR_BUTTON_STUCK, 8'h01);
        scans(1);
        i_fe.set_tick(0, 16'h00C8);
        scans(1);
        check("touch before timeout", btn, 8'h01);
        scans(12);
        check("stuck release", btn, 8'h00);
        i_fe.set_tick(0, 16'h0000);
        scans(1);
        i_fe.set_tick(0, 16'h00C8);
        scans(1);
        check("touch after real release", btn, 8'h01);
        wr(ADDR_BUTTON_STUCK, 8'h00);
        i_fe.set_tick(0, 16'h0000);
        scans(2);
    endtask
    task automatic t_comp();
        wr(ADDR_BUTTON_NEG_LIMIT, 8'h01);
        comp_cnt = 0;
        i_fe.set_tick(0, 16'hFE70);
        scans(2);
        check("negative compensation", comp_cnt[15:0], 16'h0001);
        comp_cnt = 0;
        for (int k = 0; k < 3; k++) i_fe.set_tick(k, 16'h0190);
        scans(1);
        check("average hold", hold, 8'h07);
        scans(3);
        check("three held compensation", comp_cnt[15:0], 16'h0001);
    endtask
    task automatic t_slider();
        i_fe.set_tick(3, 16'h0070);
        scans(4);
        check("slider at hysteresis", sld, 1'b0);
        i_fe.set_tick(3, 16'h0071);
        scans(3);
        check("slider debounce", sld, 1'b0);
        scans(1);
        check("slider touch", sld, 1'b1);
        i_fe.set_tick(3, 16'h0000);
        scans(4);
        check("slider release", sld, 1'b0);
    endtask
    task automatic summarize();
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge i_clk_sys) #1;
        i_rst = 1'b0;
        t_regs();
        t_debounce();
        t_single();
        t_irq();
        t_stuck();
        t_comp();
        t_slider();
        summarize();
    end
endmodule // tbs_top_bench
`default_nettype wire
